/* hdl/sarx_top.sv */
// Serial async receiver, sync transmitter, APB registers and receive FIFO
`timescale 1ns/1ps
// Functional notes
// - Enabled receiver starts on falling input edge
// - Edge starts divide-by-16 baud count
// - Start valid if count 7 low along with count 6 or 8
// - Invalid start bit abandons reception entirely
// - Count 7 agreeing with count 6 or 8 validates; take ninth count
// - Follow configured format; stop after first stop
// - Frame end: buffer, done flag, error flags
// - Length select 0 eight bits, 1 seven
// - Slave select chooses shift clock source
// - Master drives quarter baud shift clock
// - Copy buffer to shifter one cycle later
// - LSB first, change on falling edge
// - Copy to shifter sets buffer-empty flag
// - No new byte at end sets complete
module sarx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("sarx_fifo depth must be a power of two");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire  full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire  empty = (wr_q == rd_q);
    wire  push  = in_valid && !full;
    wire  pop   = out_ready && !empty;
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

module sarx_top #(
    parameter int DEPTH = sarx_pkg::FIFO_DEPTH
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial receive input
    input  wire logic        rxd,
    // Serial transmit output
    output logic             txd,
    // Shift clock pin, split into its three signals
    input  wire logic        shift_clock_pin_i,
    output logic             shift_clock_pin_o,
    output logic             shift_clock_pin_oe
);
    import sarx_pkg::*;

    initial begin
        if (DEPTH < 2) begin
            $error("sarx_top depth too small");
        end
    end

    // Register state
    logic [RXC_W-1:0] rx_control_reg_q;
    logic [TXC_W-1:0] tx_control_reg_q;
    logic [15:0]      baud_div_q;
    logic [15:0]      baud_cnt_q;
    logic             rx_done_flag_q;
    logic             parity_error_flag_q;
    logic             overrun_flag_q;
    logic             framing_error_flag_q;
    logic             tx_buffer_empty_flag_q;
    logic             tx_complete_flag_q;
    logic [31:0]      prdata_q;
    logic             pready_q;
    logic             pslverr_q;

    // APB decode
    wire acc      = psel && penable && !pready_q;
    wire done     = psel && penable && pready_q;
    wire sel_data = (paddr == OFS_DATA);
    wire sel_st   = (paddr == OFS_STATUS);
    wire sel_rxc  = (paddr == OFS_RX_CTL);
    wire sel_txc  = (paddr == OFS_TX_CTL);
    wire sel_baud = (paddr == OFS_BAUD_DIV);
    wire mapped   = sel_data || sel_st || sel_rxc || sel_txc || sel_baud;
    wire wr_done  = done && pwrite && !pslverr_q;
    wire rd_done  = done && !pwrite && !pslverr_q;
    wire wr_data  = wr_done && sel_data;
    wire wr_st    = wr_done && sel_st;

    // Receive FIFO ports
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    wire [7:0]  fifo_out_data;
    wire        fifo_pop = rd_done && sel_data;
    logic       rx_push;
    logic [7:0] rx_push_data;

    wire [ST_W-1:0] status_word = {fifo_out_valid, tx_complete_flag_q,
                                   tx_buffer_empty_flag_q, framing_error_flag_q,
                                   overrun_flag_q, parity_error_flag_q,
                                   rx_done_flag_q};
    wire [31:0] rd_mux = sel_data ? {24'h000000, fifo_out_data} :
                         sel_st   ? {{(32-ST_W){1'b0}}, status_word} :
                         sel_rxc  ? {{(32-RXC_W){1'b0}}, rx_control_reg_q} :
                         sel_txc  ? {{(32-TXC_W){1'b0}}, tx_control_reg_q} :
                         sel_baud ? {16'h0000, baud_div_q} : 32'h00000000;

    // One wait state per access; unmapped addresses answer with pslverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc && !mapped;
            if (acc && !pwrite) begin
                prdata_q <= rd_mux;
            end
        end
    end
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_control_reg_q <= RX_CTL_RST;
            tx_control_reg_q <= TX_CTL_RST;
            baud_div_q       <= BAUD_DIV_RST;
        end else if (wr_done) begin
            if (sel_rxc) begin
                rx_control_reg_q <= pwdata[RXC_W-1:0];
            end
            if (sel_txc) begin
                tx_control_reg_q <= pwdata[TXC_W-1:0];
            end
            if (sel_baud) begin
                baud_div_q <= pwdata[15:0];
            end
        end
    end

    // Baud clock enable: one pulse every baud_div_q + 1 cycles
    wire baud_tick = (baud_cnt_q >= baud_div_q);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_q <= 16'h0000;
        end else begin
            baud_cnt_q <= baud_tick ? 16'h0000 : baud_cnt_q + 16'h0001;
        end
    end

    // ---------------- Asynchronous receiver ----------------
    sarx_rx_state_e rx_st_q;
    logic [3:0]     rx_cnt_q;
    logic [3:0]     rx_bits_q;
    logic [7:0]     rx_sh_q;
    logic           rx_prev_q;
    logic           s6_q;
    logic           s7_q;
    logic           s8_q;
    logic           rx_par_q;
    logic           rx_noise_q;

    wire rx_en     = rx_control_reg_q[RXC_ENABLE] && !rx_control_reg_q[RXC_MODE];
    wire [3:0] rx_len = rx_control_reg_q[RXC_LEN] ? LEN_7 : LEN_8;
    wire take      = baud_tick && (rx_cnt_q == CNT_TAKE);
    wire start_ok  = (!s6_q && !s7_q) || (!s7_q && !s8_q);
    wire bit_ok    = (s6_q == s7_q) || (s7_q == s8_q);
    wire par_calc  = ^rx_sh_q ^ rx_control_reg_q[RXC_PAR_ODD];
    wire frame_end = take && (rx_st_q == SARX_STOP);
    // Noise on a data, parity or stop bit is reported as a framing fault
    wire framing_error_flag_now  = !rxd || rx_noise_q || !bit_ok;
    // Seven-bit frames enter from the top; realign to bit 0
    wire [7:0] rx_word = rx_control_reg_q[RXC_LEN] ? {1'b0, rx_sh_q[7:1]} : rx_sh_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q    <= SARX_IDLE;
            rx_cnt_q   <= 4'h0;
            rx_bits_q  <= 4'h0;
            rx_sh_q    <= 8'h00;
            rx_prev_q  <= 1'b1;
            s6_q       <= 1'b1;
            s7_q       <= 1'b1;
            s8_q       <= 1'b1;
            rx_par_q   <= 1'b0;
            rx_noise_q <= 1'b0;
        end else begin
            rx_prev_q <= rxd;
            if (baud_tick && rx_st_q != SARX_IDLE) begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
                if (rx_cnt_q == CNT_S6) s6_q <= rxd;
                if (rx_cnt_q == CNT_S7) s7_q <= rxd;
                if (rx_cnt_q == CNT_S8) s8_q <= rxd;
            end
            unique case (rx_st_q)
                SARX_IDLE: begin
                    if (rx_en && rx_prev_q && !rxd) begin
                        rx_st_q    <= SARX_START;
                        rx_cnt_q   <= 4'h0;
                        rx_bits_q  <= 4'h0;
                        rx_noise_q <= 1'b0;
                        rx_par_q   <= 1'b0;
                    end
                end
                SARX_START: begin
                    if (take) begin
                        rx_st_q <= start_ok ? SARX_DATA : SARX_IDLE;
                    end
                end
                SARX_DATA: begin
                    if (take) begin
                        rx_sh_q    <= {rxd, rx_sh_q[7:1]};
                        rx_noise_q <= rx_noise_q || !bit_ok;
                        rx_bits_q  <= rx_bits_q + 4'h1;
                        if (rx_bits_q + 4'h1 == rx_len) begin
                            rx_st_q <= rx_control_reg_q[RXC_PAR_EN] ? SARX_PAR : SARX_STOP;
                        end
                    end
                end
                SARX_PAR: begin
                    if (take) begin
                        rx_par_q   <= rxd ^ par_calc;
                        rx_noise_q <= rx_noise_q || !bit_ok;
                        rx_st_q    <= SARX_STOP;
                    end
                end
                SARX_STOP: begin
                    if (take) begin
                        rx_st_q <= SARX_IDLE;
                    end
                end
                default: begin
                    rx_st_q <= SARX_IDLE;
                end
            endcase
        end
    end

    assign rx_push      = frame_end;
    assign rx_push_data = rx_word;

    sarx_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rx_push),
        .in_ready  (fifo_in_ready),
        .in_data   (rx_push_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    // ---------------- Synchronous transmitter ----------------
    logic [7:0] tx_buf_q;
    logic       tx_buf_full_q;
    logic [7:0] tx_sh_q;
    logic       tx_busy_q;
    logic [3:0] tx_idx_q;
    logic [1:0] tx_ph_q;
    logic       sck_prev_q;
    logic       txd_q;
    logic       sck_o_q;
    logic       sck_oe_q;

    wire tx_sync  = tx_control_reg_q[TXC_MODE];
    wire tx_slave = tx_control_reg_q[TXC_SLAVE];
    wire [3:0] tx_len = tx_control_reg_q[TXC_LEN] ? LEN_7 : LEN_8;
    wire m_fall   = baud_tick && (tx_ph_q == PH_FALL);
    wire s_fall   = sck_prev_q && !shift_clock_pin_i;
    wire tx_fall  = tx_sync && (tx_slave ? s_fall : m_fall);
    wire tx_copy  = tx_buf_full_q && !tx_busy_q;
    wire tx_end   = tx_busy_q && tx_fall && (tx_idx_q == tx_len);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_ph_q    <= 2'h0;
            sck_prev_q <= 1'b1;
            sck_o_q    <= 1'b1;
            sck_oe_q   <= 1'b0;
        end else begin
            sck_prev_q <= shift_clock_pin_i;
            sck_oe_q   <= tx_sync && !tx_slave;
            // Two ticks high, two low; it falls on the tick that moves txd
            if (baud_tick) begin
                tx_ph_q <= tx_ph_q + 2'h1;
                sck_o_q <= (tx_ph_q[1] == tx_ph_q[0]);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buf_q      <= 8'h00;
            tx_buf_full_q <= 1'b0;
            tx_sh_q       <= 8'h00;
            tx_busy_q     <= 1'b0;
            tx_idx_q      <= 4'h0;
            txd_q         <= 1'b1;
        end else begin
            if (wr_data) begin
                tx_buf_q      <= pwdata[7:0];
                tx_buf_full_q <= 1'b1;
            end else if (tx_copy) begin
                tx_buf_full_q <= 1'b0;
            end
            if (tx_copy) begin
                tx_sh_q   <= tx_buf_q;
                tx_busy_q <= 1'b1;
                tx_idx_q  <= 4'h0;
            end else if (tx_end) begin
                tx_busy_q <= 1'b0;
                txd_q     <= 1'b1;
            end else if (tx_busy_q && tx_fall) begin
                txd_q    <= tx_sh_q[0];
                tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                tx_idx_q <= tx_idx_q + 4'h1;
            end
        end
    end
    assign txd                = txd_q;
    assign shift_clock_pin_o  = sck_o_q;
    assign shift_clock_pin_oe = sck_oe_q;

    // ---------------- Status flags: set wins over clear ----------------
    wire [ST_W-1:0] w1c = wr_st ? pwdata[ST_W-1:0] : {ST_W{1'b0}};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_done_flag_q         <= 1'b0;
            parity_error_flag_q    <= 1'b0;
            overrun_flag_q         <= 1'b0;
            framing_error_flag_q   <= 1'b0;
            tx_buffer_empty_flag_q <= 1'b1;
            tx_complete_flag_q     <= 1'b0;
        end else begin
            rx_done_flag_q <= frame_end || (rx_done_flag_q && !w1c[ST_RX_DONE]);
            parity_error_flag_q <= (frame_end && rx_par_q)
                                   || (parity_error_flag_q && !w1c[ST_PARITY_ERROR_FLAG]);
            // A full FIFO drops the new frame rather than stall the line
            overrun_flag_q <= (frame_end && !fifo_in_ready)
                              || (overrun_flag_q && !w1c[ST_OVERRUN_FLAG]);
            framing_error_flag_q <= (frame_end && framing_error_flag_now)
                                    || (framing_error_flag_q && !w1c[ST_FRAMING_ERROR_FLAG]);
            tx_buffer_empty_flag_q <= tx_copy
                                      || (tx_buffer_empty_flag_q && !w1c[ST_TX_EMPTY]
                                          && !wr_data);
            tx_complete_flag_q <= (tx_end && !tx_buf_full_q)
                                  || (tx_complete_flag_q && !w1c[ST_TX_DONE]
                                      && !wr_data);
        end
    end
endmodule

/* hdl/sarx_pkg.sv */
// Shared constants for the serial receiver and synchronous transmitter block
package sarx_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_DATA     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_RX_CTL   = 8'h08;
    localparam logic [7:0] OFS_TX_CTL   = 8'h0C;
    localparam logic [7:0] OFS_BAUD_DIV = 8'h10;
    // rx_control_reg fields
    localparam int RXC_ENABLE  = 0;
    localparam int RXC_LEN     = 1;
    localparam int RXC_MODE    = 2;
    localparam int RXC_PAR_EN  = 3;
    localparam int RXC_PAR_ODD = 4;
    localparam int RXC_W       = 5;
    // tx_control_reg fields
    localparam int TXC_LEN   = 0;
    localparam int TXC_MODE  = 1;
    localparam int TXC_SLAVE = 2;
    localparam int TXC_W     = 3;
    // serial_status_reg fields
    localparam int ST_RX_DONE  = 0;
    localparam int ST_PARITY_ERROR_FLAG     = 1;
    localparam int ST_OVERRUN_FLAG     = 2;
    localparam int ST_FRAMING_ERROR_FLAG     = 3;
    localparam int ST_TX_EMPTY = 4;
    localparam int ST_TX_DONE  = 5;
    localparam int ST_RX_AVAIL = 6;
    localparam int ST_W        = 7;
    // Reset values
    localparam logic [RXC_W-1:0] RX_CTL_RST   = 5'h00;
    localparam logic [TXC_W-1:0] TX_CTL_RST   = 3'h0;
    localparam logic [15:0]      BAUD_DIV_RST = 16'h0014;
    // Oversampling timing, counted in baud clock ticks within one bit, and frame lengths in data bits
    localparam logic [3:0] CNT_S6   = 4'h6;
    localparam logic [3:0] CNT_S7   = 4'h7;
    localparam logic [3:0] CNT_S8   = 4'h8;
    localparam logic [3:0] CNT_TAKE = 4'h9;
    localparam logic [3:0] LEN_8    = 4'h8;
    localparam logic [3:0] LEN_7    = 4'h7;
    // Synchronous shift clock: phase on which the pin falls
    localparam logic [1:0] PH_FALL  = 2'h1;
    localparam int FIFO_DEPTH = 32;
    typedef enum logic [2:0] {
        SARX_IDLE  = 3'b000,
        SARX_START = 3'b001,
        SARX_DATA  = 3'b010,
        SARX_PAR   = 3'b011,
        SARX_STOP  = 3'b100
    } sarx_rx_state_e;
endpackage

/* verif/sarx_top_properties.sv */
// Port checker for the serial block, bound into its top module
`timescale 1ns/1ps
module sarx_checker (
    // APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Serial pins
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        shift_clock_pin_i,
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe
);
    import sarx_pkg::*;
    logic        wr_hit;
    logic        want_oe_q;
    logic        arm_q;
    logic [15:0] div_q;
    logic [17:0] low_q;
    assign wr_hit = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            want_oe_q <= 1'b0;
            div_q     <= BAUD_DIV_RST;
        end else if (wr_hit && paddr == OFS_TX_CTL) begin
            want_oe_q <= pwdata[TXC_MODE] && !pwdata[TXC_SLAVE];
        end else if (wr_hit && paddr == OFS_BAUD_DIV) begin
            div_q <= pwdata[15:0];
        end
    end
    // A low phase is timed only if the pin was driven for all of it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 18'h00000;
            arm_q <= 1'b0;
        end else begin
            low_q <= shift_clock_pin_o ? 18'h00000 : low_q + 18'h00001;
            arm_q <= shift_clock_pin_oe && (shift_clock_pin_o || arm_q);
        end
    end
    default clocking dcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_PREADY_WAIT: assert property (
        psel && penable && !pready |=> pready) else $error("pready late");
    AST_PREADY_PULSE: assert property (
        pready |-> psel && penable ##1 !pready) else $error("pready not a pulse");
    AST_SLVERR_QUAL: assert property (
        pslverr |-> pready) else $error("pslverr without pready");
    AST_PRDATA_HOLD: assert property (
        $changed(prdata) |-> $past(psel && penable && !pwrite)) else $error("prdata moved");
    AST_OE_MATCH: assert property (
        $stable(want_oe_q) [*2] |-> shift_clock_pin_oe == want_oe_q)
        else $error("shift clock drive wrong");
    AST_SCLK_LOW: assert property (
        $rose(shift_clock_pin_o) && arm_q |-> low_q == {1'b0, div_q, 1'b0} + 18'h00002)
        else $error("shift clock low phase wrong");
    AST_TXD_MASTER: assert property (
        $changed(txd) && shift_clock_pin_oe |-> !shift_clock_pin_o &&
        ($past(shift_clock_pin_o) || $past(shift_clock_pin_o, 2)))
        else $error("txd moved off a clock fall");
    AST_TXD_SLAVE: assert property (
        $changed(txd) && !shift_clock_pin_oe |-> !$past(shift_clock_pin_i) &&
        ($past(shift_clock_pin_i, 2) || $past(shift_clock_pin_i, 3)))
        else $error("txd moved off an external fall");
    COV_MASTER: cover property ($fell(shift_clock_pin_o) && shift_clock_pin_oe);
    COV_SLAVE: cover property ($changed(txd) && !shift_clock_pin_oe);
    COV_UNMAPPED: cover property (pready && pslverr);
endmodule
bind sarx_top sarx_checker u_sarx_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .shift_clock_pin_i(shift_clock_pin_i),
    .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe)
);

/* verif/sarx_remote.sv */
// Remote serial device: async sender on rxd, shift receiver on txd
`timescale 1ns/1ps
module sarx_remote #(
    parameter int BIT_CYCLES = 64
) (
    // Clock
    input  wire logic pclk,
    // Serial lines
    input  wire logic txd,
    input  wire logic sclk_pin,
    output logic      rxd,
    output logic      sclk_ext
);
    logic cap_q[$];
    initial begin
        rxd = 1'b1;
        sclk_ext = 1'b1;
    end
    // Rising edge is mid-bit, since the block moves txd on falls
    always @(posedge sclk_pin) cap_q.push_back(txd);
    task automatic arm();
        cap_q = {};
    endtask
    task automatic send(input logic [8:0] v, input int n, input logic stop);
        rxd <= 1'b0;
        repeat (BIT_CYCLES) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            rxd <= v[i];
            repeat (BIT_CYCLES) @(posedge pclk);
        end
        rxd <= stop;
        repeat (BIT_CYCLES) @(posedge pclk);
        rxd <= 1'b1;
        @(posedge pclk);
    endtask
    task automatic glitch(input int len);
        rxd <= 1'b0;
        repeat (len) @(posedge pclk);
        rxd <= 1'b1;
        // Let the rejected start finish before anything else arrives
        repeat (BIT_CYCLES) @(posedge pclk);
    endtask
    // Clock stands high between frames
    task automatic run_clock(input int n);
        repeat (n) begin
            sclk_ext <= 1'b0;
            repeat (8) @(posedge pclk);
            sclk_ext <= 1'b1;
            repeat (8) @(posedge pclk);
        end
    endtask
    // Idle ones after the frame are stripped, so the MSB sent must be 0
    function automatic logic [7:0] tail(input int n);
        logic [7:0] v;
        int k;
        v = 8'h00;
        k = cap_q.size();
        while (k > 0 && cap_q[k-1] === 1'b1)
            k--;
        for (int i = 0; i < n; i++)
            v[i] = (k - n + i >= 0) ? cap_q[k - n + i] : 1'bx;
        return v;
    endfunction
endmodule

/* verif/test_serial_async_rx_sync_tx.sv */
// Self-checking bench for the serial receiver and synchronous transmitter
`timescale 1ns/1ps
module test_serial_async_rx_sync_tx;
    import sarx_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        rxd, txd, sclk_o, sclk_oe, sclk_ext;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    wire         sclk_pin = sclk_oe ? sclk_o : sclk_ext;
    int          mismatches = 0;
    int          checks_done = 0;
    sarx_top #(.DEPTH(FIFO_DEPTH)) u_sarx_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd(rxd), .txd(txd), .shift_clock_pin_i(sclk_pin), .shift_clock_pin_o(sclk_o),
        .shift_clock_pin_oe(sclk_oe));
    // Baud divider 3: tick every 4 clocks, 16 ticks a bit
    sarx_remote #(.BIT_CYCLES(64)) u_sarx_remote (
        .pclk(pclk), .txd(txd), .sclk_pin(sclk_pin), .rxd(rxd), .sclk_ext(sclk_ext));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
    endtask
    task automatic wait_done;
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        r = 32'h0;
        while (r[ST_TX_DONE] !== 1'b1 && n < 2000) begin
            apb(1'b0, OFS_STATUS, 32'h0, r, e);
            n++;
        end
        chk("tx status", 32'h30, r);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        rd_chk("status", OFS_STATUS, 32'h10);
        rd_chk("rx ctl", OFS_RX_CTL, 32'h0);
        rd_chk("tx ctl", OFS_TX_CTL, 32'h0);
        rd_chk("baud", OFS_BAUD_DIV, 32'h14);
        apb(1'b1, 8'h20, 32'hFF, r, e);
        chk("unmapped", 32'h1, {31'h0, e});
        wr(OFS_BAUD_DIV, 32'h3);
        rd_chk("baud", OFS_BAUD_DIV, 32'h3);
    endtask
    task automatic t_rx_start;
        u_sarx_remote.send(9'h0C3, 8, 1'b1);
        rd_chk("rx off", OFS_STATUS, 32'h10);
        wr(OFS_RX_CTL, 32'h01);
        u_sarx_remote.glitch(12);
        // Low for count 6 only: a single low sample must not start a frame
        u_sarx_remote.glitch(29);
        rd_chk("false start", OFS_STATUS, 32'h10);
        u_sarx_remote.send(9'h096, 8, 1'b1);
        rd_chk("rx status", OFS_STATUS, 32'h51);
        rd_chk("rx data", OFS_DATA, 32'h96);
    endtask
    task automatic t_rx_formats;
        logic [4:0] ctl [6] = '{5'h01, 5'h19, 5'h19, 5'h09, 5'h03, 5'h01};
        logic [8:0] frm [6] = '{9'h0A5, 9'h103, 9'h003, 9'h003, 9'h055, 9'h00F};
        int         nb  [6] = '{8, 9, 9, 9, 7, 8};
        logic [6:0] st  [6] = '{7'h51, 7'h51, 7'h53, 7'h51, 7'h51, 7'h59};
        for (int i = 0; i < 6; i++) begin
            wr(OFS_RX_CTL, {27'h0, ctl[i]});
            u_sarx_remote.send(frm[i], nb[i], i != 5);
            rd_chk("rx status", OFS_STATUS, {25'h0, st[i]});
            rd_chk("rx data", OFS_DATA, {24'h0, frm[i][7:0] & (i == 4 ? 8'h7F : 8'hFF)});
            wr(OFS_STATUS, 32'h0F);
            rd_chk("rx cleared", OFS_STATUS, 32'h10);
        end
    endtask
    task automatic t_fifo;
        wr(OFS_RX_CTL, 32'h01);
        for (int i = 0; i <= FIFO_DEPTH; i++)
            u_sarx_remote.send({1'b0, 8'(i)}, 8, 1'b1);
        rd_chk("overrun", OFS_STATUS, 32'h55);
        for (int i = 0; i < FIFO_DEPTH; i++)
            rd_chk("fifo data", OFS_DATA, 32'(i));
        rd_chk("drained", OFS_STATUS, 32'h15);
        wr(OFS_STATUS, 32'h0F);
    endtask
    task automatic t_tx_master;
        wr(OFS_TX_CTL, 32'h2);
        u_sarx_remote.arm();
        wr(OFS_DATA, 32'h3C);
        rd_chk("tx copied", OFS_STATUS, 32'h10);
        wr(OFS_DATA, 32'h5A);
        rd_chk("tx pending", OFS_STATUS, 32'h00);
        wait_done();
        chk("master byte", 32'h5A, {24'h0, u_sarx_remote.tail(8)});
        chk("clock drive", 32'h1, {31'h0, sclk_oe});
        wr(OFS_TX_CTL, 32'h3);
        u_sarx_remote.arm();
        wr(OFS_DATA, 32'h35);
        wait_done();
        chk("seven bits", 32'h35, {24'h0, u_sarx_remote.tail(7)});
    endtask
    task automatic t_tx_slave;
        wr(OFS_TX_CTL, 32'h6);
        u_sarx_remote.arm();
        wr(OFS_DATA, 32'h5A);
        chk("clock released", 32'h0, {31'h0, sclk_oe});
        u_sarx_remote.run_clock(12);
        rd_chk("slave status", OFS_STATUS, 32'h30);
        chk("slave byte", 32'h5A, {24'h0, u_sarx_remote.tail(8)});
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_rx_start();
        t_rx_formats();
        t_fifo();
        t_tx_master();
        t_tx_slave();
        conclude();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        conclude();
    end
endmodule
